// ### core/adcm_pkg.sv
package adcm_pkg;

    // bus geometry
    localparam int AW     = 4;
    localparam int DW     = 24;
    localparam int RES_W  = 20;

    // register map, word offsets
    localparam logic [AW-1:0] ADDR_MODE    = 4'h0;
    localparam logic [AW-1:0] ADDR_CONFIG  = 4'h1;
    localparam logic [AW-1:0] ADDR_STATUS  = 4'h2;
    localparam logic [AW-1:0] ADDR_DATA    = 4'h3;
    localparam logic [1:0]    PAGE_OFFSET  = 2'h1;   // 0x4..0x6 offset coefficients
    localparam logic [1:0]    PAGE_FSCALE  = 2'h2;   // 0x8..0xa full-scale coefficients

    // field positions
    localparam int MODE_LSB  = 0;
    localparam int RATE_LSB  = 4;
    localparam int CHAN_LSB  = 0;
    localparam int GAIN_LSB  = 8;

    // reset values and field codes
    localparam logic [3:0]    RATE_RST       = 4'h1;
    localparam logic [3:0]    RATE_RESERVED  = 4'h0;
    localparam logic [2:0]    CHAN_RST       = 3'h0;
    localparam logic [2:0]    GAIN_RST       = 3'h7;
    localparam logic [2:0]    GAIN_UNITY     = 3'h0;
    localparam logic [2:0]    GAIN_MAX       = 3'h7;
    localparam logic [1:0]    CHAN_COUNT     = 2'h3;
    localparam logic [DW-1:0] COEF_RST       = 24'h000000;

    // conversion cycles per sequence
    localparam logic [2:0] CAL_SHORT     = 3'h2;
    localparam logic [2:0] CAL_LONG      = 3'h4;
    localparam logic [2:0] FIRST_PERIODS = 3'h2;
    localparam logic [2:0] NEXT_PERIODS  = 3'h1;

    // timebase: one half-millisecond tick
    localparam int CLOCK_PERIOD_NS = 20;
    localparam int HALF_MS_NS      = 500000;
    localparam int HALF_MS_CYCLES  = HALF_MS_NS / CLOCK_PERIOD_NS;
    localparam int PRESC_W         = 15;
    localparam int PER_W           = 9;

    typedef enum logic [2:0] {
        MODE_CONT   = 3'h0,
        MODE_SINGLE = 3'h1,
        MODE_IDLE   = 3'h2,
        MODE_PDOWN  = 3'h3,
        MODE_IZS    = 3'h4,
        MODE_IFS    = 3'h5,
        MODE_SZS    = 3'h6,
        MODE_SFS    = 3'h7
    } adcm_mode_t;

    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_CAL   = 2'b01,
        ST_HALT  = 2'b11,
        ST_PDOWN = 2'b10
    } adcm_state_t;

    // settling time in ms; output period in half-ms is the same figure
    function automatic logic [PER_W-1:0] settle_ms(input logic [3:0] rate);
        case (rate)
            4'h0: settle_ms = 9'h001;  // reserved, never loaded
            4'h1: settle_ms = 9'h004;  // 470 Hz
            4'h2: settle_ms = 9'h008;  // 242 Hz
            4'h3: settle_ms = 9'h010;  // 123 Hz
            4'h4: settle_ms = 9'h020;  // 62 Hz
            4'h5: settle_ms = 9'h028;  // 50 Hz
            4'h6: settle_ms = 9'h030;  // 39 Hz
            4'h7: settle_ms = 9'h03c;  // 33.2 Hz
            4'h8: settle_ms = 9'h065;  // 19.6 Hz
            4'h9: settle_ms = 9'h078;  // 16.7 Hz
            4'ha: settle_ms = 9'h078;  // 16.7 Hz, 50 and 60 Hz rejection
            4'hb: settle_ms = 9'h0a0;  // 12.5 Hz
            4'hc: settle_ms = 9'h0c8;  // 10 Hz
            4'hd: settle_ms = 9'h0f0;  // 8.33 Hz
            4'he: settle_ms = 9'h140;  // 6.25 Hz
            default: settle_ms = 9'h1e0;  // 4.17 Hz
        endcase
    endfunction

endpackage

// ### core/adcm_seq_if.sv
`timescale 1ns/1ns
interface adcm_seq_if import adcm_pkg::*; ();
    logic          restart;
    logic          tick;
    logic          coef_we;
    logic          coef_fs;
    logic [2:0]    coef_chan;
    logic [DW-1:0] coef_wdata;
    logic [1:0]    read_chan;
    logic [DW-1:0] off_rd;
    logic [DW-1:0] fs_rd;

    modport ctrl  (output restart, coef_we, coef_fs, coef_chan, coef_wdata, read_chan,
                   input tick, off_rd, fs_rd);
    modport timer (input restart, output tick);
    modport store (input coef_we, coef_fs, coef_chan, coef_wdata, read_chan,
                   output off_rd, fs_rd);
endinterface

// ### core/adcm_rate_timer.sv
`timescale 1ns/1ns
module adcm_rate_timer import adcm_pkg::*; #(
    parameter int unsigned HALF_MS_CYCLES_P = HALF_MS_CYCLES
) (
    input  wire logic       clock,
    input  wire logic       reset_n,
    input  wire logic       ce,
    input  wire logic [3:0] rate,
    adcm_seq_if.timer       seq
);
    logic [PRESC_W-1:0] presc_q;
    logic [PER_W-1:0]   per_q;
    logic               tick_q;
    wire                half_tick;
    wire                period_end;

    // period is half the settling time: settle_ms half-ms ticks
    assign half_tick  = presc_q == PRESC_W'(HALF_MS_CYCLES_P - 1);
    assign period_end = half_tick && (per_q == settle_ms(rate) - 9'h001);
    assign seq.tick   = tick_q;

    // restart clears both counters so a new sequence starts on a clean period
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            presc_q <= '0;
            per_q   <= '0;
            tick_q  <= 1'b0;
        end else if (ce) begin
            presc_q <= (seq.restart || half_tick) ? '0 : presc_q + 1'b1;
            if (seq.restart || period_end) begin
                per_q <= '0;
            end else if (half_tick) begin
                per_q <= per_q + 1'b1;
            end
            tick_q  <= period_end && !seq.restart;
        end
    end
endmodule

// ### core/adcm_coef_store.sv
`timescale 1ns/1ns
module adcm_coef_store import adcm_pkg::*; (
    input  wire logic clock,
    input  wire logic reset_n,
    input  wire logic ce,
    adcm_seq_if.store seq
);
    logic [DW-1:0] off_mem [3];
    logic [DW-1:0] fs_mem  [3];
    wire           chan_ok;
    wire           rd_ok;

    // channel codes above the last input are dropped, not aliased
    assign chan_ok    = seq.coef_chan < {1'b0, CHAN_COUNT};
    assign rd_ok      = seq.read_chan < CHAN_COUNT;
    assign seq.off_rd = rd_ok ? off_mem[seq.read_chan] : '0;
    assign seq.fs_rd  = rd_ok ? fs_mem[seq.read_chan] : '0;

    // zero-scale fills the offset slot, full-scale the gain slot
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 3; i++) begin
                off_mem[i] <= COEF_RST;
                fs_mem[i]  <= COEF_RST;
            end
        end else if (ce && seq.coef_we && chan_ok) begin
            if (seq.coef_fs) begin
                fs_mem[seq.coef_chan[1:0]] <= seq.coef_wdata;
            end else begin
                off_mem[seq.coef_chan[1:0]] <= seq.coef_wdata;
            end
        end
    end
endmodule

// ### core/adcm_mode_cal_ctrl.sv
`timescale 1ns/1ns
module adcm_mode_cal_ctrl import adcm_pkg::*; #(
    parameter int unsigned HALF_MS_CYCLES_P = HALF_MS_CYCLES
) (
    input  wire logic             clock,
    input  wire logic             reset_n,
    input  wire logic             ce,
    input  wire logic [AW-1:0]    addr,
    input  wire logic [DW-1:0]    wr_data,
    input  wire logic             wr_en,
    input  wire logic             rd_en,
    output wire logic [DW-1:0]    rd_data,
    input  wire logic [RES_W-1:0] adc_result,
    output wire logic             conversion_ready_n,
    output wire logic             filter_reset,
    output wire logic             modulator_clock_en,
    output wire logic             analog_power_en,
    output wire logic             clock_output_en,
    output wire logic             input_short,
    output wire logic             fullscale_connect
);

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic adcm_state_t state_of(input adcm_mode_t m);
        unique case (m)
            MODE_CONT, MODE_SINGLE:              state_of = ST_RUN;
            MODE_IDLE:                           state_of = ST_HALT;
            MODE_PDOWN:                          state_of = ST_PDOWN;
            MODE_IZS, MODE_IFS, MODE_SZS, MODE_SFS: state_of = ST_CAL;
        endcase
    endfunction

    // internal full-scale needs extra cycles once the amplifier has gain
    function automatic logic [2:0] cal_len(input adcm_mode_t m, input logic [2:0] g);
        cal_len = (m == MODE_IFS && g != GAIN_UNITY) ? CAL_LONG : CAL_SHORT;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // state

    adcm_mode_t    mode_q;
    adcm_mode_t    mode_d;
    adcm_state_t   state_q;
    adcm_state_t   state_d;
    logic [3:0]    rate_q;
    logic [3:0]    rate_d;
    logic [2:0]    chan_q;
    logic [2:0]    chan_d;
    logic [2:0]    gain_q;
    logic [2:0]    gain_d;
    logic [2:0]    cyc_left_q;
    logic [2:0]    cyc_left_d;
    logic          ready_n_q;
    logic          ready_n_d;
    logic [RES_W-1:0] data_q;
    logic          cal_err_q;
    logic          cal_err_d;
    logic [DW-1:0] rd_data_q;
    logic          filter_reset_q;
    logic          modclk_q;
    logic          power_q;
    logic          clock_output_q;
    logic          short_q;
    logic          fsconn_q;

    adcm_seq_if seq ();

    ////////////////////////////////////////////////////////////////////////////////
    // bus decode

    wire           wr_mode;
    wire           wr_cfg;
    wire           rd_dat;
    wire           rd_off;
    wire           rd_fs;
    wire adcm_mode_t wr_code;
    wire [3:0]     wr_rate;
    wire           refuse;
    wire adcm_mode_t mode_wr_val;
    wire [DW-1:0]  status_word;
    wire [DW-1:0]  rd_mux;

    // strobes qualified by ce, since a frozen block must not absorb a write
    assign wr_mode     = ce && wr_en && addr == ADDR_MODE;
    assign wr_cfg      = ce && wr_en && addr == ADDR_CONFIG;
    assign rd_dat      = ce && rd_en && addr == ADDR_DATA;
    assign rd_off      = addr[3:2] == PAGE_OFFSET;
    assign rd_fs       = addr[3:2] == PAGE_FSCALE;
    assign wr_code     = adcm_mode_t'(wr_data[MODE_LSB +: 3]);
    assign wr_rate     = wr_data[RATE_LSB +: 4];

    // internal full-scale at top gain cannot be done; park in idle and flag it
    assign refuse      = wr_mode && wr_code == MODE_IFS && gain_q == GAIN_MAX;
    assign mode_wr_val = refuse ? MODE_IDLE : wr_code;

    // read mux; unmapped words read as zero
    assign status_word = {{(DW-7){1'b0}}, mode_q, state_q, cal_err_q, ready_n_q};
    assign rd_mux =
        (addr == ADDR_MODE)   ? {{(DW-8){1'b0}}, rate_q, 1'b0, mode_q} :
        (addr == ADDR_CONFIG) ? {{(DW-11){1'b0}}, gain_q, 5'h00, chan_q} :
        (addr == ADDR_STATUS) ? status_word :
        (addr == ADDR_DATA)   ? {{(DW-RES_W){1'b0}}, data_q} :
        rd_off                ? seq.off_rd :
        rd_fs                 ? seq.fs_rd : '0;
    assign seq.read_chan = addr[1:0];

    ////////////////////////////////////////////////////////////////////////////////
    // sequencing

    wire running;
    wire restart_req;
    wire last_tick;
    wire result_load;
    wire cal_done;

    // a mode or configuration write aborts whatever was in flight
    assign running     = state_q == ST_RUN || state_q == ST_CAL;
    assign restart_req = wr_mode || wr_cfg;
    assign last_tick   = ce && running && seq.tick && cyc_left_q == NEXT_PERIODS
                         && !restart_req;
    assign result_load = last_tick && state_q == ST_RUN;
    assign cal_done    = last_tick && state_q == ST_CAL;
    assign seq.restart = restart_req || !running;

    // coefficient lands in the slot of the channel in use
    assign seq.coef_we    = cal_done;
    assign seq.coef_fs    = mode_q[0];
    assign seq.coef_chan  = chan_q;
    assign seq.coef_wdata = {{(DW-RES_W){1'b0}}, adc_result};

    // mode register: software write wins, hardware steps to idle or power-down
    assign mode_d = wr_mode ? mode_wr_val :
                    cal_done ? MODE_IDLE :
                    (result_load && mode_q == MODE_SINGLE) ? MODE_PDOWN : mode_q;
    assign state_d = state_of(mode_d);
    assign rate_d  = (wr_mode && wr_rate != RATE_RESERVED) ? wr_rate : rate_q;
    assign chan_d  = wr_cfg ? wr_data[CHAN_LSB +: 3] : chan_q;
    assign gain_d  = wr_cfg ? wr_data[GAIN_LSB +: 3] : gain_q;

    // periods still to run in this sequence
    assign cyc_left_d =
        restart_req ? (mode_d[2] ? cal_len(mode_d, gain_d) : FIRST_PERIODS) :
        last_tick   ? NEXT_PERIODS :
        (ce && running && seq.tick) ? cyc_left_q - 3'h1 : cyc_left_q;

    // ready: a finished result or calibration beats a simultaneous data read
    assign ready_n_d = (result_load || cal_done) ? 1'b0 :
                       (wr_mode && mode_wr_val[2]) ? 1'b1 :
                       rd_dat ? 1'b1 : ready_n_q;
    assign cal_err_d = refuse ? 1'b1 : (wr_mode ? 1'b0 : cal_err_q);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            mode_q     <= MODE_CONT;
            state_q    <= ST_RUN;
            rate_q     <= RATE_RST;
            chan_q     <= CHAN_RST;
            gain_q     <= GAIN_RST;
            cyc_left_q <= FIRST_PERIODS;
        end else if (ce) begin
            mode_q     <= mode_d;
            state_q    <= state_d;
            rate_q     <= rate_d;
            chan_q     <= chan_d;
            gain_q     <= gain_d;
            cyc_left_q <= cyc_left_d;
        end
    end

    // flags and captured result
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ready_n_q <= 1'b1;
            cal_err_q <= 1'b0;
            data_q    <= '0;
        end else if (ce) begin
            ready_n_q <= ready_n_d;
            cal_err_q <= cal_err_d;
            if (result_load) begin
                data_q <= adc_result;
            end
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rd_data_q <= '0;
        end else if (ce) begin
            rd_data_q <= rd_en ? rd_mux : '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // analog controls, registered from the next state so they track state_q

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            filter_reset_q <= 1'b0;
            modclk_q       <= 1'b1;
            power_q        <= 1'b1;
            clock_output_q       <= 1'b1;
            short_q        <= 1'b0;
            fsconn_q       <= 1'b0;
        end else if (ce) begin
            filter_reset_q <= state_d == ST_HALT || state_d == ST_PDOWN;
            modclk_q       <= state_d != ST_PDOWN;
            power_q        <= state_d != ST_PDOWN;
            clock_output_q       <= state_d != ST_PDOWN;
            short_q        <= state_d == ST_CAL && mode_d == MODE_IZS;
            fsconn_q       <= state_d == ST_CAL && mode_d == MODE_IFS;
        end
    end

    assign rd_data            = rd_data_q;
    assign conversion_ready_n = ready_n_q;
    assign filter_reset       = filter_reset_q;
    assign modulator_clock_en = modclk_q;
    assign analog_power_en    = power_q;
    assign clock_output_en    = clock_output_q;
    assign input_short        = short_q;
    assign fullscale_connect  = fsconn_q;

    ////////////////////////////////////////////////////////////////////////////////
    // submodules

    adcm_rate_timer #(
        .HALF_MS_CYCLES_P (HALF_MS_CYCLES_P)
    ) u_timer (
        .clock   (clock),
        .reset_n (reset_n),
        .ce      (ce),
        .rate    (rate_q),
        .seq     (seq.timer)
    );

    adcm_coef_store u_store (
        .clock   (clock),
        .reset_n (reset_n),
        .ce      (ce),
        .seq     (seq.store)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // checks; helper counts period ticks since the last restart

    logic [3:0] ticks_q;
    logic       first_q;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ticks_q <= 4'h0;
            first_q <= 1'b1;
        end else if (ce) begin
            if (restart_req) begin
                ticks_q <= 4'h0;
            end else if (running && seq.tick && ticks_q != 4'hf) begin
                ticks_q <= ticks_q + 4'h1;
            end
            first_q <= restart_req ? 1'b1 : (result_load ? 1'b0 : first_q);
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    a_result_ready:
        assert property (result_load |=> !conversion_ready_n && data_q == $past(adc_result))
        else $error("result did not raise ready");
    a_first_two_periods:
        assert property (result_load && first_q |-> ticks_q == 4'h1)
        else $error("first result not after two periods");
    a_idle_filter_reset:
        assert property (state_q == ST_HALT |-> filter_reset && !input_short)
        else $error("idle without filter reset");
    a_idle_mod_clock:
        assert property (state_q == ST_HALT |-> modulator_clock_en)
        else $error("idle stopped modulator clock");
    a_pdown_all_off:
        assert property (state_q == ST_PDOWN |-> !analog_power_en && !clock_output_en
                         && !modulator_clock_en)
        else $error("power-down left circuitry on");
    a_short_only_izs:
        assert property (input_short |-> state_q == ST_CAL && mode_q == MODE_IZS)
        else $error("input short outside zero-scale calibration");
    a_cal_two_cycles:
        assert property (cal_done && (mode_q == MODE_IZS || mode_q == MODE_SFS)
                         |-> ticks_q == 4'h1)
        else $error("calibration length not two cycles");
    a_cal_start_ready:
        assert property (wr_mode && mode_wr_val[2] |=> conversion_ready_n
                         && state_q == ST_CAL)
        else $error("ready not high at calibration start");
    a_cal_end_idle:
        assert property (cal_done |=> mode_q == MODE_IDLE && state_q == ST_HALT
                         && !conversion_ready_n)
        else $error("calibration did not end in idle");
    a_offset_store:
        assert property (seq.coef_we && !seq.coef_fs |-> state_q == ST_CAL
                         && (mode_q == MODE_IZS || mode_q == MODE_SZS))
        else $error("offset written outside zero-scale");
    a_fscale_store:
        assert property (seq.coef_we && seq.coef_fs |-> state_q == ST_CAL
                         && (mode_q == MODE_IFS || mode_q == MODE_SFS))
        else $error("full-scale written outside full-scale");
    a_ifs_unity_two:
        assert property (cal_done && mode_q == MODE_IFS && gain_q == GAIN_UNITY
                         |-> ticks_q == 4'h1)
        else $error("unity gain full-scale not two cycles");
    a_ifs_gain_four:
        assert property (cal_done && mode_q == MODE_IFS && gain_q != GAIN_UNITY
                         |-> ticks_q == 4'h3)
        else $error("gained full-scale not four cycles");
    a_szs_two:
        assert property (cal_done && mode_q == MODE_SZS |-> ticks_q == 4'h1)
        else $error("system zero-scale not two cycles");
    a_rate_defined:
        assert property (rate_q != RATE_RESERVED)
        else $error("reserved rate code in use");

    c_cont_result:  cover property (result_load && !first_q);
    c_izs_done:     cover property (cal_done && mode_q == MODE_IZS);
    c_ifs_long:     cover property (cal_done && mode_q == MODE_IFS && gain_q != GAIN_UNITY);
    c_refused:      cover property (refuse);
    c_pdown:        cover property (state_q == ST_PDOWN);

endmodule

// ### verif/adcm_front_model.sv
`timescale 1ns/1ns
module adcm_front_model import adcm_pkg::*; (
    input  wire logic             clock,
    input  wire logic             filter_reset,
    input  wire logic             analog_power_en,
    input  wire logic [RES_W-1:0] level,
    output logic      [RES_W-1:0] adc_result
);
    initial adc_result = 20'h00000;
    // a filter held off gives no steady word, so toggle rather than hold the last one
    always @(posedge clock) begin
        if (filter_reset || !analog_power_en) begin
            adc_result <= ~adc_result;
        end else begin
            adc_result <= level;
        end
    end
endmodule

// ### verif/adc_mode_calibration_control_tb.sv
`timescale 1ns/1ns
module adc_mode_calibration_control_tb import adcm_pkg::*; ;
    localparam int P = 4;  // half-ms tick shortened to four clocks
    localparam int ST [16] = '{1, 4, 8, 16, 32, 40, 48, 60, 101, 120, 120, 160, 200, 240, 320, 480};
    localparam int CM [5] = '{4, 5, 5, 6, 7};
    localparam int CG [5] = '{0, 0, 3, 0, 7};
    localparam int CN [5] = '{2, 2, 4, 2, 2};
    logic             clock = 1'b0;
    logic             reset_n = 1'b0;
    logic [AW-1:0]    addr = 4'h0;
    logic [DW-1:0]    wr_data = 24'h000000;
    logic             wr_en = 1'b0;
    logic             rd_en = 1'b0;
    logic             ce = 1'b1;
    logic [DW-1:0]    rd_data;
    logic [RES_W-1:0] adc_result;
    logic [RES_W-1:0] level = 20'h5a5a5;
    logic             conversion_ready_n, filter_reset, modulator_clock_en;
    logic             analog_power_en, clock_output_en, input_short, fullscale_connect;
    logic [DW-1:0]    d;
    int               n, cyc, bad_count, cmp_count;

    always #10 clock = ~clock;
    adcm_mode_cal_ctrl #(.HALF_MS_CYCLES_P(P)) DUT (.clock(clock), .reset_n(reset_n), .ce(ce),
        .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .adc_result(adc_result), .conversion_ready_n(conversion_ready_n),
        .filter_reset(filter_reset), .modulator_clock_en(modulator_clock_en),
        .analog_power_en(analog_power_en), .clock_output_en(clock_output_en),
        .input_short(input_short), .fullscale_connect(fullscale_connect));
    adcm_front_model FRONT (.clock(clock), .filter_reset(filter_reset),
        .analog_power_en(analog_power_en), .level(level), .adc_result(adc_result));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            bad_count++;
        end
    endtask
    // latency figures get a little slack since the edge that counts is the designer's choice
    task automatic near(input int got, input int exp);
        cmp_count++;
        if (got < exp - 2 || got > exp + 2) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            bad_count++;
        end
    endtask
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
        addr <= a;
        wr_data <= v;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
        #1;  // a following call must not reassign the strobe in this time step
    endtask
    task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] v);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1 v = rd_data;
    endtask
    task automatic wait_rdy(output int k);
        k = 0;
        while (conversion_ready_n !== 1'b0 && k < 5000) begin
            @(posedge clock);
            #1 k++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // cycle ceiling well above the longest rate sweep
    always @(posedge clock) begin
        cyc++;
        if (cyc == 60000) begin
            bad_count++;
            close_out();
        end
    end

    initial begin
        repeat (6) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        #1 chk(24'({conversion_ready_n, filter_reset, modulator_clock_en, analog_power_en,
            clock_output_en, input_short, fullscale_connect}), 24'h00005c);
        rd(ADDR_MODE, d);
        chk(d, 24'h000010);
        rd(ADDR_CONFIG, d);
        chk(d, 24'h000700);
        rd(4'hf, d);
        chk(d, 24'h000000);
        wr(ADDR_MODE, 24'h000012);
        #1 chk(24'({filter_reset, modulator_clock_en, analog_power_en, clock_output_en}), 24'hf);
        wr(ADDR_MODE, 24'h000013);
        #1 chk(24'({filter_reset, modulator_clock_en, analog_power_en, clock_output_en}), 24'h8);
        // each calibration kind; system inputs are set before the mode write starts it
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_CONFIG, {13'h0, 3'(CG[i]), 8'h01});
            level <= 20'h0a000 + 20'(i);
            wr(ADDR_MODE, {16'h0, 4'h1, 1'b0, 3'(CM[i])});
            #1 chk(24'({conversion_ready_n, input_short, fullscale_connect}), 24'({1'b1, CM[i] == 4, CM[i] == 5}));
            wait_rdy(n);
            near(n, CN[i] * ST[1] * P + 1);
            rd(ADDR_MODE, d);
            chk(d, 24'h000012);
            rd((CM[i] % 2 == 0) ? 4'h5 : 4'h9, d);
            chk(d, {4'h0, level});
        end
        // top-gain internal full-scale is parked in idle and flagged
        wr(ADDR_MODE, 24'h000015);
        rd(ADDR_STATUS, d);
        chk(d, 24'h00002e);
        // a frozen block ignores the write
        ce <= 1'b0;
        wr(ADDR_MODE, 24'h000013);
        ce <= 1'b1;
        rd(ADDR_MODE, d);
        chk(d, 24'h000012);
        // single conversion: one result two periods on, then power-down
        rd(ADDR_DATA, d);
        wr(ADDR_MODE, 24'h000011);
        wait_rdy(n);
        near(n, 2 * ST[1] * P + 1);
        rd(ADDR_MODE, d);
        chk(d, 24'h000013);
        level <= 20'h5a5a5;
        // every rate code but the reserved 0: first result after two periods, then one period apart
        for (int r = 1; r < 16; r++) begin
            rd(ADDR_DATA, d);
            wr(ADDR_MODE, {16'h0, 4'(r), 4'h0});
            wait_rdy(n);
            near(n, 2 * ST[r] * P + 1);
            rd(ADDR_DATA, d);
            chk(d, {4'h0, level});
            wait_rdy(n);
            near(n, ST[r] * P - 1);
        end
        wr(ADDR_MODE, 24'h000000);
        rd(ADDR_MODE, d);
        chk(d, 24'h0000f0);
        close_out();
    end
endmodule
